// ### rtl/timer_cfg.svh
// timing counts and field positions for the dual interval timer
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define CLK_PERIOD_PS       5000
`define BOARD_CLK_KHZ       3000
`define T1_PRESCALE         64
`define T2_PRESCALE         192
`define T2_FAST_PRESCALE    144
`define T1_TICK_CYCLES      ((`T1_PRESCALE * 1000000 / `BOARD_CLK_KHZ) / 5)
`define T2_TICK_CYCLES      ((`T2_PRESCALE * 1000000 / `BOARD_CLK_KHZ) / 5)
`define T2_FAST_CYCLES      ((`T2_FAST_PRESCALE * 1000000 / `BOARD_CLK_KHZ) / 5)
`define T1_WIDTH            14
`define T1_LOAD_BITS        15
`define T1_MODE_BIT         0
`define T1_IRQ_LEVEL        3
`define T2_IRQ_LEVEL        4
`define T2_WIDTH            8
`define CTRL_RESET          1'b0

`endif

// ### rtl/timer_pkg.sv
// types shared by the dual interval timer
package timer_pkg;

  typedef enum logic {ModeInterrupt, ModeClock} t1_mode_t;

  typedef struct packed {
    logic       valid;
    logic       bitValue;
  } serial_bit_t;

  typedef struct packed {
    logic       write;
    logic       intervalLoadFlag;
    logic       controlLoadFlag;
    logic       fastClockSelect;
    logic [7:0] interval;
  } t2_write_t;

endpackage

// ### rtl/tick_counter.sv
// down counter with prescaler, raising done when it reaches zero
`timescale 1ns/10ps
`default_nettype none
`include "timer_cfg.svh"

module tick_counter #(
  parameter int WIDTH    = 14,
  parameter int DIV_BITS = 16
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                load,
  input  wire logic [WIDTH-1:0]    loadValue,
  input  wire logic [DIV_BITS-1:0] tickCycles,
  output logic [WIDTH-1:0]         count,
  output logic                     done
);

  initial begin
    if (WIDTH < 1 || DIV_BITS < 2) begin
      $error("tick_counter: unsupported parameters");
    end
  end

  logic [DIV_BITS-1:0] divReg;
  logic [DIV_BITS-1:0] divNext;
  logic [WIDTH-1:0]    countReg;
  logic [WIDTH-1:0]    countNext;
  logic                runReg;
  logic                runNext;
  logic                doneNext;
  logic                doneReg;

  always_comb begin
    divNext   = divReg;
    countNext = countReg;
    runNext   = runReg;
    doneNext  = 1'b0;
    if (load) begin
      countNext = loadValue;
      divNext   = tickCycles - {{(DIV_BITS-1){1'b0}}, 1'b1};
      runNext   = (loadValue != '0);
      doneNext  = (loadValue == '0);
    end else if (runReg) begin
      if (divReg == '0) begin
        divNext   = tickCycles - {{(DIV_BITS-1){1'b0}}, 1'b1};
        countNext = countReg - {{(WIDTH-1){1'b0}}, 1'b1};
        if (countReg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
          runNext  = 1'b0;
          doneNext = 1'b1;
        end
      end else begin
        divNext = divReg - {{(DIV_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divReg   <= '0;
      countReg <= '0;
      runReg   <= 1'b0;
      doneReg  <= 1'b0;
    end else begin
      divReg   <= divNext;
      countReg <= countNext;
      runReg   <= runNext;
      doneReg  <= doneNext;
    end
  end

  assign count = countReg;
  assign done  = doneReg;

endmodule
`default_nettype wire

// ### rtl/dual_interval_timer.sv
// two interval timers with latched interrupt requests on levels 3 and 4
//
// Behaviour
// - first timer completion raises level 3, second timer raises level 4
// - first timer decrements once per 4266-cycle (21.330 us) period
// - first timer count is 14 bits; extra supplied bits are ignored
// - first timer runs unattended and requests interrupt at zero
// - writing zero to bit 0 returns controller to interrupt mode
// - mask bit 3 one in interrupt mode enables level 3, clears pending
// - second timer decrements every 64 us when fast clock select is zero
// - second timer interval accepted only while interval load flag set
// - control load flag clear skips control register on a write
// - loading second interval starts countdown; level 4 if enabled
// - first timer rate is board clock divided by 64
// - interrupt mode for one period captures count; clock mode reads it
`timescale 1ns/10ps
`default_nettype none
`include "timer_cfg.svh"

module dual_interval_timer
  import timer_pkg::*;
#(
  parameter int T1_WIDTH = `T1_WIDTH,
  parameter int T2_WIDTH = `T2_WIDTH
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire timer_pkg::serial_bit_t   serialIn,
  input  wire logic                     modeWrite,
  input  wire logic                     modeValue,
  input  wire logic                     mask3Write,
  input  wire logic                     mask3Value,
  input  wire timer_pkg::t2_write_t     t2Write,
  input  wire logic                     mask4Write,
  input  wire logic                     mask4Value,
  input  wire logic                     irq4Clear,
  output logic                          irqLevel3,
  output logic                          irqLevel4,
  output logic                          clockMode,
  output logic [T1_WIDTH-1:0]           t1ReadCount,
  output logic [T2_WIDTH-1:0]           t2Count,
  output logic                          fastClockSelect
);

  initial begin
    if (T1_WIDTH != `T1_WIDTH || T2_WIDTH < 1 || T2_WIDTH > 16) begin
      $error("dual_interval_timer: unsupported widths");
    end
  end

  localparam int T1_DIV = `T1_TICK_CYCLES;
  localparam int T2_DIV = `T2_TICK_CYCLES;
  localparam int T2_FDIV = `T2_FAST_CYCLES;
  localparam logic [4:0] LAST_BIT = 5'(`T1_LOAD_BITS - 1);

  // ------------------------------------------------------------
  // first timer: serial load and mode
  // ------------------------------------------------------------
  t1_mode_t            modeReg;
  t1_mode_t            modeNext;
  logic [4:0]          bitCntReg;
  logic [4:0]          bitCntNext;
  logic [T1_WIDTH-1:0] shiftReg;
  logic [T1_WIDTH-1:0] shiftNext;
  logic                t1Load;
  logic [T1_WIDTH-1:0] t1Live;
  logic                t1Done;
  logic [T1_WIDTH-1:0] captureReg;
  logic [T1_WIDTH-1:0] captureNext;
  logic [15:0]         holdReg;
  logic [15:0]         holdNext;

  always_comb begin
    modeNext    = modeReg;
    bitCntNext  = bitCntReg;
    shiftNext   = shiftReg;
    t1Load      = 1'b0;
    captureNext = captureReg;
    holdNext    = holdReg;
    if (serialIn.valid) begin
      if (bitCntReg == 5'h0) begin
        // mode bit arrives first
        modeNext   = serialIn.bitValue ? ModeClock : ModeInterrupt;
        bitCntNext = 5'h1;
      end else begin
        // interval bits fill from bit 1 upward; only 14 are kept
        shiftNext = {serialIn.bitValue, shiftReg[T1_WIDTH-1:1]};
        if (bitCntReg == LAST_BIT) begin
          bitCntNext = 5'h0;
          t1Load     = 1'b1;
        end else begin
          bitCntNext = bitCntReg + 5'h1;
        end
      end
    end else if (modeWrite) begin
      modeNext   = modeValue ? ModeClock : ModeInterrupt;
      bitCntNext = 5'h0;
    end
    // capture running count after a full period in interrupt mode
    if (modeReg == ModeInterrupt) begin
      if (holdReg != 16'hffff) begin
        holdNext = holdReg + 16'h1;
      end
      if (holdReg == 16'(T1_DIV - 1)) begin
        captureNext = t1Live;
      end
    end else begin
      holdNext = 16'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg    <= ModeInterrupt;
      bitCntReg  <= 5'h0;
      shiftReg   <= '0;
      captureReg <= '0;
      holdReg    <= 16'h0;
    end else begin
      modeReg    <= modeNext;
      bitCntReg  <= bitCntNext;
      shiftReg   <= shiftNext;
      captureReg <= captureNext;
      holdReg    <= holdNext;
    end
  end

  tick_counter #(
    .WIDTH    (T1_WIDTH),
    .DIV_BITS (16)
  ) firstTimer (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (t1Load),
    .loadValue  ({serialIn.bitValue, shiftReg[T1_WIDTH-1:1]}),
    .tickCycles (16'(T1_DIV)),
    .count      (t1Live),
    .done       (t1Done)
  );

  // ------------------------------------------------------------
  // second timer: flagged register loads
  // ------------------------------------------------------------
  logic                fastReg;
  logic                fastNext;
  logic                t2Load;
  logic [T2_WIDTH-1:0] t2Live;
  logic                t2Done;

  always_comb begin
    fastNext = fastReg;
    t2Load   = 1'b0;
    if (t2Write.write) begin
      if (t2Write.controlLoadFlag) begin
        fastNext = t2Write.fastClockSelect;
      end
      // the interval loads only when the interval flag is set, whatever the control flag
      if (t2Write.intervalLoadFlag) begin
        t2Load = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastReg <= `CTRL_RESET;
    end else begin
      fastReg <= fastNext;
    end
  end

  tick_counter #(
    .WIDTH    (T2_WIDTH),
    .DIV_BITS (16)
  ) secondTimer (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (t2Load),
    .loadValue  (t2Write.interval[T2_WIDTH-1:0]),
    .tickCycles (fastNext ? 16'(T2_FDIV) : 16'(T2_DIV)),
    .count      (t2Live),
    .done       (t2Done)
  );

  // ------------------------------------------------------------
  // interrupt levels
  // ------------------------------------------------------------
  logic en3Reg;
  logic en3Next;
  logic pend3Reg;
  logic pend3Next;
  logic en4Reg;
  logic en4Next;
  logic pend4Reg;
  logic pend4Next;
  logic irq3Reg;
  logic irq4Reg;
  logic [T1_WIDTH-1:0] readReg;
  logic [T2_WIDTH-1:0] t2CountReg;
  logic clockModeReg;

  always_comb begin
    en3Next   = en3Reg;
    pend3Next = pend3Reg;
    en4Next   = en4Reg;
    pend4Next = pend4Reg;
    if (mask3Write && modeReg == ModeInterrupt) begin
      en3Next = mask3Value;
      if (mask3Value) begin
        pend3Next = 1'b0;
      end
    end
    if (mask4Write) begin
      en4Next = mask4Value;
    end
    if (irq4Clear) begin
      pend4Next = 1'b0;
    end
    // a completion in the clearing cycle wins
    if (t1Done) begin
      pend3Next = 1'b1;
    end
    if (t2Done) begin
      pend4Next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en3Reg       <= 1'b0;
      pend3Reg     <= 1'b0;
      en4Reg       <= 1'b0;
      pend4Reg     <= 1'b0;
      irq3Reg      <= 1'b0;
      irq4Reg      <= 1'b0;
      readReg      <= '0;
      t2CountReg   <= '0;
      clockModeReg <= 1'b0;
    end else begin
      en3Reg       <= en3Next;
      pend3Reg     <= pend3Next;
      en4Reg       <= en4Next;
      pend4Reg     <= pend4Next;
      irq3Reg      <= pend3Next & en3Next;
      irq4Reg      <= pend4Next & en4Next;
      readReg      <= captureNext;
      t2CountReg   <= t2Live;
      clockModeReg <= (modeNext == ModeClock);
    end
  end

  assign irqLevel3       = irq3Reg;
  assign irqLevel4       = irq4Reg;
  assign clockMode       = clockModeReg;
  assign t1ReadCount     = readReg;
  assign t2Count         = t2CountReg;
  assign fastClockSelect = fastReg;

endmodule
`default_nettype wire

// ### verification/dual_interval_timer_monitor.sv
// concurrent checks on the dual interval timer ports
`timescale 1ns/10ps
`default_nettype none
module dual_interval_timer_monitor
  import timer_pkg::*;
#(
  parameter int T1_WIDTH = 14,
  parameter int T2_WIDTH = 8
) (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire timer_pkg::serial_bit_t serialIn,
  input wire logic                   modeWrite,
  input wire logic                   modeValue,
  input wire logic                   mask3Write,
  input wire logic                   mask3Value,
  input wire timer_pkg::t2_write_t   t2Write,
  input wire logic                   mask4Write,
  input wire logic                   mask4Value,
  input wire logic                   irq4Clear,
  input wire logic                   irqLevel3,
  input wire logic                   irqLevel4,
  input wire logic                   clockMode,
  input wire logic [T1_WIDTH-1:0]    t1ReadCount,
  input wire logic [T2_WIDTH-1:0]    t2Count,
  input wire logic                   fastClockSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic en4_reg;
  logic en4_next;
  always_comb en4_next = mask4Write ? mask4Value : en4_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) en4_reg <= 1'b0;
    else en4_reg <= en4_next;
  end
  a_irq3_held: assert property (
    irqLevel3 && !mask3Write && !modeWrite && !serialIn.valid |=> irqLevel3)
    else $error("irq3 dropped");
  a_irq4_held: assert property (
    irqLevel4 && !irq4Clear && !mask4Write && !t2Write.write |=> irqLevel4)
    else $error("irq4 dropped");
  a_irq4_clear: assert property (
    irq4Clear && !t2Write.write && $past(t2Count, 3) == t2Count
    |=> !irqLevel4) else $error("irq4 kept");
  a_mask3_clear: assert property (
    !clockMode && mask3Write && mask3Value && !serialIn.valid
    |=> !irqLevel3) else $error("irq3 kept");
  a_mode_write: assert property (
    modeWrite && !serialIn.valid |=> clockMode == $past(modeValue))
    else $error("mode not written");
  a_t2_load: assert property (
    t2Write.write && t2Write.intervalLoadFlag
    |=> ##1 t2Count == $past(t2Write.interval, 2)) else $error("no load");
  a_t2_keep: assert property (
    !(t2Write.write && t2Write.intervalLoadFlag)
    && !$past(t2Write.write && t2Write.intervalLoadFlag)
    |=> t2Count == $past(t2Count)
    || t2Count == $past(t2Count) - 1'b1) else $error("count jumped");
  a_ctrl_skip: assert property (
    t2Write.write |=> fastClockSelect == ($past(t2Write.controlLoadFlag)
    ? $past(t2Write.fastClockSelect) : $past(fastClockSelect)))
    else $error("control load wrong");
  a_irq4_rise: assert property (
    en4_reg && t2Count == 8'h00 && $past(t2Count) == 8'h01
    |-> ##[0:3] irqLevel4) else $error("irq4 late");
endmodule
bind dual_interval_timer dual_interval_timer_monitor #(
  .T1_WIDTH(T1_WIDTH), .T2_WIDTH(T2_WIDTH)) monitor (.*);
`default_nettype wire

// ### verification/host_serial_model.sv
// host model shifting the 15-bit first-timer load word
`timescale 1ns/10ps
`default_nettype none
module host_serial_model
  import timer_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              start,
  input  wire logic [13:0]       interval,
  output timer_pkg::serial_bit_t serialIn
);
  logic [14:0] word_reg = 15'h0000;
  logic [3:0]  left_reg = 4'h0;
  logic        idle_reg = 1'b0;
  // idle data line toggles so no stale bit is seen
  always @(posedge clk) begin
    idle_reg <= ~idle_reg;
    if (start && left_reg == 4'h0) begin
      word_reg <= {interval, 1'b1};
      left_reg <= 4'hf;
    end else if (left_reg != 4'h0) begin
      word_reg <= word_reg >> 1;
      left_reg <= left_reg - 4'h1;
    end
  end
  assign serialIn = '{left_reg != 4'h0,
                      left_reg != 4'h0 ? word_reg[0] : idle_reg};
endmodule
`default_nettype wire

// ### verification/dual_interval_timer_tb_top.sv
// self-checking bench for the dual interval timer
`timescale 1ns/10ps
`default_nettype none
module dual_interval_timer_tb_top;
  import timer_pkg::*;
  localparam int T1T = 4266;
  localparam int T2T = 12800;
  typedef struct packed {
    t2_write_t  w;
    logic [7:0] cnt;
    logic       fast;
  } row_t;
  row_t rows [3] = '{
    '{'{1'b1, 1'b1, 1'b0, 1'b1, 8'h5a}, 8'h5a, 1'b0},
    '{'{1'b1, 1'b0, 1'b1, 1'b1, 8'h11}, 8'h5a, 1'b1},
    '{'{1'b1, 1'b1, 1'b1, 1'b0, 8'h03}, 8'h03, 1'b0}};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic [13:0] interval = 14'h0003;
  serial_bit_t serialIn;
  logic        modeWrite = 1'b0, modeValue = 1'b0;
  logic        mask3Write = 1'b0, mask3Value = 1'b1;
  t2_write_t   t2Write = '0;
  logic        mask4Write = 1'b0, mask4Value = 1'b1, irq4Clear = 1'b0;
  logic        irqLevel3, irqLevel4, clockMode, fastClockSelect;
  logic [13:0] t1ReadCount;
  logic [7:0]  t2Count;
  int          n_fail = 0, compares = 0, cyc = 0, t1s, t2s;
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  dual_interval_timer DUT (.*);
  host_serial_model host (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic upto(input int n);
    while (cyc < n) tick(1);
  endtask
  task automatic irq(input logic four, input int n);
    while (cyc < n && (four ? irqLevel4 : irqLevel3) !== 1'b1) tick(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic load();
    start = 1'b1;
    tick(1);
    start = 1'b0;
    t1s = cyc;
    tick(20);
  endtask
  task automatic final_report;
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report;
  end
  initial begin
    tick(4);
    rst_n = 1'b1;
    chk({irqLevel3, irqLevel4, clockMode, t2Count} === 11'h000, "reset");
    pulse(mask4Write);
    pulse(mask3Write);
    foreach (rows[i]) begin
      t2Write = rows[i].w;
      tick(1);
      t2Write = '0;
      tick(1);
      chk({t2Count, fastClockSelect} === rows[i][8:0], "row");
    end
    t2Write = '0;
    t2s = cyc;
    load();
    chk(clockMode === 1'b1, "clock mode");
    upto(t1s + 2 * T1T - 5);
    chk(irqLevel3 === 1'b0, "irq3 early");
    irq(1'b0, t1s + 3 * T1T + 40);
    chk(irqLevel3 === 1'b1, "irq3 missing");
    pulse(mask3Write);
    tick(4);
    chk(irqLevel3 === 1'b1, "irq3 not held");
    pulse(modeWrite);
    chk(clockMode === 1'b0, "mode kept");
    pulse(mask3Write);
    tick(1);
    chk(irqLevel3 === 1'b0, "irq3 kept");
    interval = 14'h0064;
    load();
    pulse(modeWrite);
    tick(T1T + 10);
    modeValue = 1'b1;
    pulse(modeWrite);
    tick(1);
    chk(t1ReadCount < 14'h0064 && t1ReadCount > 14'h0060, "capture");
    upto(t2s + 2 * T2T - 5);
    chk(irqLevel4 === 1'b0, "irq4 early");
    irq(1'b1, t2s + 4 * T2T + 40);
    tick(8);
    chk(irqLevel4 === 1'b1, "irq4 missing");
    pulse(irq4Clear);
    tick(1);
    chk(irqLevel4 === 1'b0, "irq4 kept");
    final_report;
  end
endmodule
`default_nettype wire
